// ==== logic/fdf_decimator.sv ====
/*
 * FIR decimator: circular delay line, reversed coefficient store,
 * one multiply-accumulate per cycle, rounding, saturation and a
 * two-entry output buffer toward the D/A port.
 * Assumes adc_data_i is stable while the strobe is high and the cycle
 * after it, and that the D/A side may stall with dac_ready_i.
 */
`timescale 1ns/1ps
module fdf_decimator
  import fdf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // A/D input port and sample-rate timer
  input wire logic adc_strobe_i,
  input wire logic [SAMPLE_W-1:0] adc_data_i,
  // Coefficient load port
  input wire logic coef_we_i,
  input wire logic [PTR_W-1:0] coef_addr_i,
  input wire logic [SAMPLE_W-1:0] coef_data_i,
  // D/A output port
  output logic [SAMPLE_W-1:0] dac_data_o,
  output logic dac_valid_o,
  input wire logic dac_ready_i,
  // Status
  output logic busy_o,
  output logic sat_o
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  fdf_state_t state_r;
  fdf_state_t state_nxt;
  logic strobe_d_r;
  logic pending_r;
  logic [SAMPLE_W-1:0] data_r [TAPS];
  logic [SAMPLE_W-1:0] coef_r [TAPS];
  logic [PTR_W-1:0] delay_line_pointer_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W-1:0] coefficient_pointer_r;
  logic [PTR_W-1:0] tap_cnt_r;
  logic [CNT_W-1:0] decim_count_r;
  logic [ACC_W-1:0] acc_r;
  logic [SAMPLE_W-1:0] result_r;
  logic sat_r;
  logic busy_r;
  logic [SAMPLE_W-1:0] head_data_r;
  logic head_vld_r;
  logic [SAMPLE_W-1:0] tail_data_r;
  logic tail_vld_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire strobe_rise = adc_strobe_i & ~strobe_d_r; // [RL13]
  wire start_in = (state_r == S_IDLE) && (strobe_rise || pending_r);
  wire take_in = (state_r == S_FETCH);
  wire count_zero = (decim_count_r == '0);
  wire pass_go = (state_r == S_TEST) && count_zero;
  wire in_mac = (state_r == S_MAC) || (state_r == S_LAST);
  wire buf_room = ~tail_vld_r;
  wire push = (state_r == S_EMIT) && buf_room;
  wire pop = head_vld_r & dac_ready_i;
  wire last_tap = (tap_cnt_r == PTR_W'(TAPS - 2));
  wire coef_wr = coef_we_i && (state_r == S_IDLE);

  // Circular successors
  wire [PTR_W-1:0] wr_next = (delay_line_pointer_r == PTR_W'(TAPS - 1)) ?
                             PTR_RST : delay_line_pointer_r + 1'b1;
  wire [PTR_W-1:0] rd_next = (rd_ptr_r == PTR_W'(TAPS - 1)) ?
                             PTR_RST : rd_ptr_r + 1'b1;
  wire [PTR_W-1:0] cp_next = (coefficient_pointer_r == PTR_W'(TAPS - 1)) ?
                             PTR_RST : coefficient_pointer_r + 1'b1;

  // ----------------------------------------------------------------
  // Multiply, round, saturate
  // ----------------------------------------------------------------
  wire signed [SAMPLE_W-1:0] tap_sample = data_r[rd_ptr_r];
  wire signed [SAMPLE_W-1:0] tap_coef = coef_r[coefficient_pointer_r];
  wire signed [PROD_W-1:0] product = tap_sample * tap_coef; // [RL4]
  wire [ACC_W-1:0] product_ext = ACC_W'(product);
  wire [ACC_W-1:0] acc_sum = acc_r + product_ext; // [RL11]
  wire [ACC_W-1:0] acc_rnd = acc_sum + ROUND_VAL; // [RL11]
  wire [SAMPLE_W-1:0] accumulator_upper_word = acc_r[FRAC_SHIFT +: SAMPLE_W];
  wire [ACC_W-FRAC_SHIFT-SAMPLE_W:0] acc_top = acc_r[ACC_W-1:FRAC_SHIFT+SAMPLE_W-1];
  wire accumulator_overflow_flag = ~((&acc_top) | ~(|acc_top)); // [RL12]
  wire [SAMPLE_W-1:0] sat_word = acc_r[ACC_W-1] ? SAT_NEG : SAT_POS;
  wire [SAMPLE_W-1:0] out_word = accumulator_overflow_flag ?
                                 sat_word : accumulator_upper_word; // [RL12]

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (strobe_rise || pending_r) begin
          state_nxt = S_FETCH;
        end
      end
      S_FETCH: state_nxt = S_TEST;
      S_TEST: state_nxt = count_zero ? S_LOAD : S_IDLE; // [RL3]
      S_LOAD: state_nxt = S_MAC;
      S_MAC: begin
        if (last_tap) begin
          state_nxt = S_LAST;
        end
      end
      S_LAST: state_nxt = S_SAT;
      S_SAT: state_nxt = S_EMIT;
      S_EMIT: begin
        if (buf_room) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
      strobe_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != S_IDLE);
      strobe_d_r <= adc_strobe_i;
    end
  end

  // Strobe seen mid-pass is held; an idle edge and a held strobe share one take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_r <= 1'b0;
    end else if (strobe_rise && !(state_r == S_IDLE)) begin
      pending_r <= 1'b1;
    end else if (start_in) begin
      pending_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Delay line and decimation counter
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < TAPS; i++) begin : g_store
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          data_r[i] <= SAMPLE_RST;
          coef_r[i] <= COEF_RST;
        end else begin
          if (take_in && delay_line_pointer_r == PTR_W'(i)) begin
            data_r[i] <= adc_data_i; // [RL2] [RL10] [RL6]
          end
          if (coef_wr && coef_addr_i == PTR_W'(i)) begin
            coef_r[i] <= coef_data_i; // [RL8]
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_line_pointer_r <= PTR_RST;
    end else if (take_in) begin
      delay_line_pointer_r <= wr_next; // [RL2]
    end
  end

  // Own storage element, preset to M before the first sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decim_count_r <= DECIM_LOAD; // [RL13] [RL16]
    end else if (take_in) begin
      decim_count_r <= decim_count_r - 1'b1; // [RL3]
    end else if (pass_go) begin
      decim_count_r <= DECIM_LOAD; // [RL3] [RL1] [RL5]
    end
  end

  // ----------------------------------------------------------------
  // Filter pass, one tap per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ptr_r <= PTR_RST;
      coefficient_pointer_r <= PTR_RST;
      tap_cnt_r <= PTR_RST;
      acc_r <= '0;
    end else if (state_r == S_LOAD) begin
      rd_ptr_r <= delay_line_pointer_r; // [RL8] [RL9]
      coefficient_pointer_r <= PTR_RST; // [RL7]
      tap_cnt_r <= PTR_RST;
      acc_r <= '0; // [RL11]
    end else if (in_mac) begin
      rd_ptr_r <= rd_next;
      coefficient_pointer_r <= cp_next; // [RL7]
      tap_cnt_r <= tap_cnt_r + 1'b1;
      acc_r <= (state_r == S_LAST) ? acc_rnd : acc_sum; // [RL11] [RL14]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= SAMPLE_RST;
      sat_r <= 1'b0;
    end else if (state_r == S_SAT) begin
      result_r <= out_word; // [RL12]
      sat_r <= accumulator_overflow_flag;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_vld_r <= 1'b0;
      tail_vld_r <= 1'b0;
      head_data_r <= SAMPLE_RST;
      tail_data_r <= SAMPLE_RST;
    end else if (pop && tail_vld_r) begin
      head_data_r <= tail_data_r;
      tail_vld_r <= push;
      tail_data_r <= push ? result_r : tail_data_r;
    end else if (pop || !head_vld_r) begin
      head_vld_r <= push; // [RL18]
      head_data_r <= push ? result_r : head_data_r; // [RL6]
    end else if (push) begin
      tail_vld_r <= 1'b1;
      tail_data_r <= result_r;
    end
  end

  assign dac_data_o = head_data_r;
  assign dac_valid_o = head_vld_r;
  assign busy_o = busy_r;
  assign sat_o = sat_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int OUT_LAT_MAX = CYC_OUTPUT_MAX; // [RL15]

  logic [CNT_W-1:0] chk_in_cnt_r;
  logic [PTR_W-1:0] chk_start_r;
  logic chk_started_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_in_cnt_r <= '0;
      chk_start_r <= PTR_RST;
      chk_started_r <= 1'b0;
    end else begin
      if (push) begin
        chk_in_cnt_r <= '0;
      end else if (take_in) begin
        chk_in_cnt_r <= chk_in_cnt_r + 1'b1;
      end
      if (state_r == S_LOAD) begin
        chk_start_r <= delay_line_pointer_r;
        chk_started_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_one_per_m: assert property ( // [RL1]
    push |-> chk_in_cnt_r == CNT_W'(DECIM))
    else $error("output not after exactly M inputs");

  a_wr_advance: assert property ( // [RL2]
    take_in |=> delay_line_pointer_r == $past(wr_next)
                && data_r[$past(delay_line_pointer_r)] == $past(adc_data_i))
    else $error("sample not stored or index not advanced");

  a_count_reload: assert property ( // [RL3]
    (state_r == S_TEST && count_zero) |=> state_r == S_LOAD
                                          && decim_count_r == DECIM_LOAD)
    else $error("counter zero did not start pass with reload");

  a_count_wait: assert property ( // [RL3]
    (state_r == S_TEST && !count_zero) |=> state_r == S_IDLE
                                           && $stable(decim_count_r))
    else $error("nonzero counter did not return to wait");

  a_coef_wrap: assert property ( // [RL7]
    (state_r == S_SAT) |-> coefficient_pointer_r == PTR_RST
                           && tap_cnt_r == PTR_RST
                           && rd_ptr_r == delay_line_pointer_r)
    else $error("coefficient pointer did not wrap after N taps");

  a_start_step: assert property ( // [RL9]
    (state_r == S_LOAD && chk_started_r) |->
      delay_line_pointer_r == PTR_W'(chk_start_r + PTR_W'(DECIM)))
    else $error("pass start did not advance by M");

  a_acc_clear: assert property ( // [RL11]
    (state_r == S_LOAD) |=> acc_r == '0 ##1 acc_r == $past(product_ext))
    else $error("accumulator not cleared at pass start");

  a_sat_limit: assert property ( // [RL12]
    (state_r == S_SAT && accumulator_overflow_flag) |=> sat_r
      && (result_r == SAT_POS || result_r == SAT_NEG))
    else $error("overflow not saturated");

  a_out_latency: assert property ( // [RL14]
    (state_r == S_TEST && count_zero && buf_room && !pop) |->
      ##[1:OUT_LAT_MAX] push)
    else $error("output took longer than budget");

  a_valid_hold: assert property ( // [RL18]
    (dac_valid_o && !dac_ready_i) |=> dac_valid_o && $stable(dac_data_o))
    else $error("output word dropped under stall");

  a_strobe_take: assert property ( // [RL13]
    (state_r == S_IDLE && strobe_rise) |=> take_in)
    else $error("idle strobe edge did not fetch a sample");

  a_ptr_hold: assert property ( // [RL10]
    !take_in |=> $stable(delay_line_pointer_r))
    else $error("write index moved without a sample");

  a_pass_len: assert property ( // [RL14]
    (state_r == S_LOAD) |-> ##9 state_r == S_SAT)
    else $error("filter pass not one cycle per tap");

  a_plain_word: assert property ( // [RL12]
    (state_r == S_SAT && !accumulator_overflow_flag) |=> !sat_r
      && result_r == $past(accumulator_upper_word))
    else $error("unsaturated result not the upper word");

  a_buf_shift: assert property ( // [RL18]
    (pop && tail_vld_r) |=> head_vld_r && dac_data_o == $past(tail_data_r))
    else $error("second buffer entry not moved to head");

  c_output: cover property (push);
  c_stall: cover property (push && tail_vld_r == 1'b0 && head_vld_r && !dac_ready_i);
  c_saturate: cover property (state_r == S_SAT && accumulator_overflow_flag);
  c_strobe_busy: cover property (strobe_rise && state_r == S_MAC);

endmodule // fdf_decimator

// ==== logic/fdf_pkg.sv ====
/*
 * Constants, state type and timing budget of the FIR decimation filter.
 * Assumes one 10 MHz processing clock and a sample strobe much slower
 * than one output pass.
 */
// Function
// RL1: One output per M stored inputs
// RL2: Strobe stores sample, advances circular write index
// RL3: Decrement counter; zero starts pass, reloads M
// RL4: Output is sum of N sample-coefficient products
// RL5: Output rate equals input rate over M
// RL6: Samples from converter port, results to output port
// RL7: Coefficient pointer walks all N, wraps to start
// RL8: Oldest sample first; coefficients stored reversed
// RL9: Pass start address advances M per output
// RL10: Delay line holds latest N samples
// RL11: Clear accumulator, N-1 signed products, round last
// RL12: Saturate on overflow, send upper word
// RL13: Counter preset to M; strobe edge detected
// RL14: One cycle per tap, at most 18+N
// RL15: Overhead budget per stage as listed
// RL16: Decimation counter in its own storage element
// RL17: Coefficients must band-limit to half output rate
// RL18: Width, N, M fixed; valid pulse per word
package fdf_pkg;

  // ----------------------------------------------------------------
  // Data path shape
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int TAPS = 8;
  localparam int DECIM = 4;
  localparam int ACC_W = 40;
  localparam int PROD_W = 2 * SAMPLE_W;
  localparam int FRAC_SHIFT = SAMPLE_W - 1;
  localparam int PTR_W = $clog2(TAPS);
  localparam int CNT_W = $clog2(DECIM + 1);

  // ----------------------------------------------------------------
  // Reset values and saturation limits
  // ----------------------------------------------------------------
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;
  localparam logic [SAMPLE_W-1:0] COEF_RST = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
  localparam logic [CNT_W-1:0] DECIM_LOAD = CNT_W'(DECIM);
  localparam logic [SAMPLE_W-1:0] SAT_POS = 16'h7fff;
  localparam logic [SAMPLE_W-1:0] SAT_NEG = 16'h8000;
  localparam logic [ACC_W-1:0] ROUND_VAL = ACC_W'(1) << (FRAC_SHIFT - 1);

  // ----------------------------------------------------------------
  // Cycle budget per output
  // ----------------------------------------------------------------
  localparam int CYC_STROBE = 2;
  localparam int CYC_FETCH = 1;
  localparam int CYC_WRITE = 1;
  localparam int CYC_COUNT = 4;
  localparam int CYC_RELOAD = 2;
  localparam int CYC_PASS_OVH = 7;
  localparam int CYC_RETURN = 1;
  localparam int CYC_OVERHEAD = CYC_STROBE + CYC_FETCH + CYC_WRITE + CYC_COUNT
                                + CYC_RELOAD + CYC_PASS_OVH + CYC_RETURN;
  localparam int CYC_OUTPUT_MAX = CYC_OVERHEAD + TAPS;

  typedef enum logic [3:0] {
    S_IDLE,
    S_FETCH,
    S_TEST,
    S_LOAD,
    S_MAC,
    S_LAST,
    S_SAT,
    S_EMIT
  } fdf_state_t;

endpackage

// ==== test/fdf_conv_model.sv ====
/* Converter-side model: sample timer with A/D port, D/A sink.
   Assumes the bench supplies sample_i and steers run_i and stall_i. */
`timescale 1ns/1ps
module fdf_conv_model
  import fdf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic run_i,
  input wire logic stall_i,
  input wire logic [7:0] period_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic take_o,
  // A/D side
  output logic adc_strobe_o,
  output logic [SAMPLE_W-1:0] adc_data_o,
  // D/A side
  input wire logic [SAMPLE_W-1:0] dac_data_i,
  input wire logic dac_valid_i,
  output logic dac_ready_o,
  output logic pop_o,
  output logic [SAMPLE_W-1:0] word_o
);
  logic [7:0] ph_r;
  logic [SAMPLE_W-1:0] held_r;
  // ----
  // Timer and ports
  // ----
  // Strobe is a 3-cycle level, only its rise counts
  assign adc_strobe_o = run_i && (ph_r < 8'h03);
  // Word valid near the strobe only, else inverted
  assign adc_data_o = (run_i && ph_r < 8'h04) ? held_r : ~held_r;
  assign dac_ready_o = !stall_i;
  always_ff @(posedge clk_i) begin
    take_o <= 1'b0;
    pop_o <= dac_valid_i && dac_ready_o;
    word_o <= dac_data_i;
    if (rst_i || !run_i) begin
      ph_r <= 8'hff;
    end else if (ph_r >= period_i - 8'h01) begin
      ph_r <= 8'h00;
      held_r <= sample_i;
      take_o <= 1'b1;
    end else begin
      ph_r <= ph_r + 8'h01;
    end
  end
endmodule // fdf_conv_model

// ==== test/fdf_decimator_tb.sv ====
/* Self-checking bench of the FIR decimator with a converter model.
   Assumes the package constants TAPS, DECIM and the Q15 format. */
`timescale 1ns/1ps
module fdf_decimator_tb
  import fdf_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic coef_we_i = 1'b0;
  logic [PTR_W-1:0] coef_addr_i = 3'h0;
  logic [SAMPLE_W-1:0] coef_data_i = 16'h0000;
  logic run = 1'b0;
  logic stall = 1'b0;
  logic [7:0] period = 8'h28;
  logic [SAMPLE_W-1:0] sample = 16'h0000;
  logic adc_strobe_i, dac_valid_o, dac_ready_i, busy_o, sat_o, take, pop;
  logic [SAMPLE_W-1:0] adc_data_i, dac_data_o, word;
  logic [31:0] seed = 32'h7b20;
  logic [SAMPLE_W-1:0] coef [TAPS];
  logic [SAMPLE_W-1:0] xs [$];
  logic [16:0] expq [$];
  logic [16:0] e;
  logic st_q = 1'b0;
  logic vq = 1'b0;
  bit chk_sat = 1'b1;
  int errors = 0;
  int tests_run = 0;
  int nin = 0;
  int lat = 0;

  fdf_decimator i_fdf_decimator (.clk_i(clk_i), .rst_i(rst_i),
    .adc_strobe_i(adc_strobe_i), .adc_data_i(adc_data_i), .coef_we_i(coef_we_i),
    .coef_addr_i(coef_addr_i), .coef_data_i(coef_data_i), .dac_data_o(dac_data_o),
    .dac_valid_o(dac_valid_o), .dac_ready_i(dac_ready_i), .busy_o(busy_o),
    .sat_o(sat_o));
  fdf_conv_model i_fdf_conv_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .stall_i(stall), .period_i(period), .sample_i(sample), .take_o(take),
    .adc_strobe_o(adc_strobe_i), .adc_data_o(adc_data_i), .dac_data_i(dac_data_o),
    .dac_valid_i(dac_valid_o), .dac_ready_o(dac_ready_i), .pop_o(pop), .word_o(word));

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Oldest sample meets location 0, rounded, saturated
  function automatic logic [16:0] fir_ref(int n);
    longint acc;
    longint x;
    acc = 64'sd16384;
    for (int k = 0; k < TAPS; k++) begin
      x = (n - TAPS + k >= 0) ? longint'($signed(xs[n-TAPS+k])) : 64'sd0;
      acc += x * longint'($signed(coef[k]));
    end
    if (acc >= 64'sd1073741824) return {1'b1, SAT_POS};
    if (acc < -64'sd1073741824) return {1'b1, SAT_NEG};
    return {1'b0, acc[30:15]};
  endfunction
  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic load_coefs(input bit fix, input logic [SAMPLE_W-1:0] v);
    for (int a = 0; a < TAPS; a++) begin
      @(posedge clk_i);
      seed = lfsr(seed);
      coef[a] = fix ? v : seed[15:0];
      coef_we_i <= 1'b1;
      coef_addr_i <= a[PTR_W-1:0];
      coef_data_i <= coef[a];
    end
    @(posedge clk_i);
    coef_we_i <= 1'b0;
  endtask
  task automatic stream(input int n, input logic [7:0] per);
    int target;
    target = nin + n;
    @(posedge clk_i);
    period <= per;
    run <= 1'b1;
    for (int i = 0; i < 20000 && nin < target; i++) @(posedge clk_i);
    cyc(5);
    run <= 1'b0;
    for (int i = 0; i < 500 && (expq.size() > 0 || busy_o !== 1'b0); i++) cyc(1);
  endtask
  // ----
  // Monitor
  // ----
  always @(posedge clk_i) begin
    st_q <= adc_strobe_i;
    vq <= dac_valid_o;
    lat <= (adc_strobe_i && !st_q) ? 0 : lat + 1;
    if (adc_strobe_i && !st_q && chk_sat) chk(busy_o === 1'b0, "busy at strobe");
    if (dac_valid_o && !vq && chk_sat) chk(lat <= CYC_OUTPUT_MAX, "slow output");
    if (take) begin
      xs.push_back(sample);
      nin++;
      if (nin % DECIM == 0) expq.push_back(fir_ref(nin));
      seed = lfsr(seed);
      if (sample !== SAT_POS && sample !== SAT_NEG) sample <= seed[15:0];
    end
    if (pop) begin
      chk(expq.size() > 0, "extra word");
      if (expq.size() > 0) begin
        e = expq.pop_front();
        chk(word === e[15:0], "word mismatch");
        if (chk_sat) chk(sat_o === e[16], "sat flag");
      end
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    cyc(16);
    rst_i <= 1'b0;
    cyc(2);
    chk({dac_valid_o, busy_o, sat_o, dac_data_o} === 19'h0, "reset state");
    sample <= 16'h1234;
    load_coefs(1'b0, 16'h0000);
    for (int r = 0; r < 3; r++) stream(16, 8'h28 + {3'h0, seed[4:0]});
    chk_sat <= 1'b0;
    fork
      stream(16, 8'h28);
      begin
        cyc(100);
        stall <= 1'b1;
        cyc(250);
        stall <= 1'b0;
      end
    join
    chk_sat <= 1'b1;
    load_coefs(1'b1, SAT_POS);
    sample <= SAT_POS;
    stream(12, 8'h28);
    sample <= SAT_NEG;
    stream(12, 8'h28);
    chk(expq.size() == 0 && nin % DECIM == 0, "missing word");
    end_of_test();
  end
  initial begin
    cyc(20000);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // fdf_decimator_tb
